//--- rtl/dpgpio_params.svh
`ifndef DPGPIO_PARAMS_SVH
`define DPGPIO_PARAMS_SVH
`define DPGPIO_ADDR_PORT0_DATA 8'h80
`define DPGPIO_ADDR_PORT1_DATA 8'h90
`define DPGPIO_ADDR_PORT0_DIR 8'h94
`define DPGPIO_ADDR_PORT0_SEL 8'h95
`define DPGPIO_ADDR_PORT1_DIR 8'h96
`define DPGPIO_ADDR_PORT1_SEL 8'h97
`define DPGPIO_RST_DATA 8'hff
`define DPGPIO_RST_DIR 8'hff
`define DPGPIO_RST_SEL 8'h00
`define DPGPIO_RST_P1_DATA 3'h7
`define DPGPIO_RST_PORT1_DIRECTION 3'h7
`define DPGPIO_RST_P1_SEL 3'h0
`define DPGPIO_BIT_RXD 1
`define DPGPIO_BIT_TXD 2
`define DPGPIO_BIT_IRQA 3
`define DPGPIO_BIT_IRQB 4
`define DPGPIO_BIT_T0 5
`define DPGPIO_BIT_T1 6
`define DPGPIO_BIT_PWM 7
`endif

//--- rtl/dpgpio_pkg.sv
package dpgpio_pkg;
  typedef enum logic [1:0] {
    DPGPIO_ROUTE_OFF = 2'h0,
    DPGPIO_ROUTE_PINS = 2'h1,
    DPGPIO_ROUTE_RADIO = 2'h2,
    DPGPIO_ROUTE_RSVD = 2'h3
  } dpgpio_route_t;
endpackage : dpgpio_pkg

//--- rtl/dpgpio_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpgpio_params.svh"
module dpgpio_pin_mux
  import dpgpio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] spi_route,
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe,
  input wire logic [1:0] p1_pin_in,
  output logic [1:0] p1_pin_out,
  output logic [1:0] p1_pin_oe,
  input wire logic input_only_pin,
  input wire logic uart_txd,
  output logic uart_rxd,
  input wire logic uart_rxd_out,
  input wire logic pwm_out,
  output logic ext_irq_a_n,
  output logic ext_irq_b_n,
  output logic timer0_count_in,
  output logic timer1_count_in,
  output logic timer2_count_in,
  input wire logic spi_sck,
  input wire logic spi_sdo,
  output logic spi_sdi
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] p0_data_q, port0_direction_q, p0_sel_q;
  logic [2:0] p1_data_q, port1_direction_q, p1_sel_q;
  logic [7:0] p0_meta_q, p0_sync_q;
  logic [2:0] p1_meta_q, p1_sync_q;
  logic [7:0] p0_oe_d, p0_out_d;
  logic [1:0] p1_oe_d, p1_out_d;
  logic spi_on;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      p0_data_q <= `DPGPIO_RST_DATA;
      port0_direction_q <= `DPGPIO_RST_DIR;
      p0_sel_q <= `DPGPIO_RST_SEL;
      p1_data_q <= `DPGPIO_RST_P1_DATA;
      port1_direction_q <= `DPGPIO_RST_PORT1_DIRECTION;
      p1_sel_q <= `DPGPIO_RST_P1_SEL;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `DPGPIO_ADDR_PORT0_DATA: p0_data_q <= sfr_wdata;
        `DPGPIO_ADDR_PORT0_DIR: port0_direction_q <= sfr_wdata;
        `DPGPIO_ADDR_PORT0_SEL: p0_sel_q <= sfr_wdata;
        `DPGPIO_ADDR_PORT1_DATA: p1_data_q <= sfr_wdata[2:0];
        `DPGPIO_ADDR_PORT1_DIR: port1_direction_q <= sfr_wdata[2:0];
        `DPGPIO_ADDR_PORT1_SEL: p1_sel_q <= sfr_wdata[2:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pins are asynchronous; two flops before any use
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      p0_meta_q <= 8'h00;
      p0_sync_q <= 8'h00;
      p1_meta_q <= 3'h0;
      p1_sync_q <= 3'h0;
    end else begin
      p0_meta_q <= p0_pin_in;
      p0_sync_q <= p0_meta_q;
      p1_meta_q <= {input_only_pin, p1_pin_in};
      p1_sync_q <= p1_meta_q;
    end
  end

  // ****************************************
  // Port0 direction and output mux
  // ****************************************
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p0_oe_d[i] = ~port0_direction_q[i];
      p0_out_d[i] = p0_data_q[i];
    end
    // Bit 0 never looks at its select bit; boot memory select
    if (p0_sel_q[`DPGPIO_BIT_RXD]) begin
      p0_oe_d[`DPGPIO_BIT_RXD] = ~port0_direction_q[`DPGPIO_BIT_RXD];
      p0_out_d[`DPGPIO_BIT_RXD] = uart_rxd_out;
    end
    if (p0_sel_q[`DPGPIO_BIT_TXD]) begin
      p0_oe_d[`DPGPIO_BIT_TXD] = 1'b1;
      p0_out_d[`DPGPIO_BIT_TXD] = uart_txd;
    end
    for (int j = `DPGPIO_BIT_IRQA; j <= `DPGPIO_BIT_T1; j++) begin
      if (p0_sel_q[j]) begin
        p0_oe_d[j] = 1'b0;
      end
    end
    if (p0_sel_q[`DPGPIO_BIT_PWM]) begin
      p0_oe_d[`DPGPIO_BIT_PWM] = 1'b1;
      p0_out_d[`DPGPIO_BIT_PWM] = pwm_out;
    end
  end

  // ****************************************
  // Port1 routing
  // ****************************************
  assign spi_on = (dpgpio_route_t'(spi_route) == DPGPIO_ROUTE_PINS);
  always_comb begin
    p1_oe_d = ~port1_direction_q[1:0];
    p1_out_d = p1_data_q[1:0];
    if (spi_on) begin
      p1_oe_d = 2'h3;
      p1_out_d = {spi_sdo, spi_sck};
    end else if (p1_sel_q[0]) begin
      p1_oe_d[0] = 1'b0;
    end
  end

  // Outputs registered; all inputs under reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      p0_pin_oe <= 8'h00;
      p0_pin_out <= 8'h00;
      p1_pin_oe <= 2'h0;
      p1_pin_out <= 2'h0;
    end else begin
      p0_pin_oe <= p0_oe_d;
      p0_pin_out <= p0_out_d;
      p1_pin_oe <= p1_oe_d;
      p1_pin_out <= p1_out_d;
    end
  end

  // Peripheral inputs; UART and IRQ idle high, timer and SPI inputs idle low when not selected
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      uart_rxd <= 1'b1;
      ext_irq_a_n <= 1'b1;
      ext_irq_b_n <= 1'b1;
      timer0_count_in <= 1'b0;
      timer1_count_in <= 1'b0;
      timer2_count_in <= 1'b0;
      spi_sdi <= 1'b0;
    end else begin
      uart_rxd <= p0_sel_q[`DPGPIO_BIT_RXD] ? p0_sync_q[`DPGPIO_BIT_RXD] : 1'b1;
      ext_irq_a_n <= p0_sel_q[`DPGPIO_BIT_IRQA] ? p0_sync_q[`DPGPIO_BIT_IRQA] : 1'b1;
      ext_irq_b_n <= p0_sel_q[`DPGPIO_BIT_IRQB] ? p0_sync_q[`DPGPIO_BIT_IRQB] : 1'b1;
      timer0_count_in <= p0_sel_q[`DPGPIO_BIT_T0] & p0_sync_q[`DPGPIO_BIT_T0];
      timer1_count_in <= p0_sel_q[`DPGPIO_BIT_T1] & p0_sync_q[`DPGPIO_BIT_T1];
      timer2_count_in <= ~spi_on & p1_sel_q[0] & p1_sync_q[0];
      spi_sdi <= spi_on & p1_sync_q[2];
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    case (sfr_addr)
      `DPGPIO_ADDR_PORT0_DATA: sfr_rdata = (p0_pin_oe & p0_data_q) | (~p0_pin_oe & p0_sync_q);
      `DPGPIO_ADDR_PORT0_DIR: sfr_rdata = port0_direction_q;
      `DPGPIO_ADDR_PORT0_SEL: sfr_rdata = p0_sel_q;
      `DPGPIO_ADDR_PORT1_DATA:
        sfr_rdata = {5'h00, p1_sync_q[2], (p1_pin_oe & p1_data_q[1:0]) | (~p1_pin_oe & p1_sync_q[1:0])};
      `DPGPIO_ADDR_PORT1_DIR: sfr_rdata = {5'h00, port1_direction_q};
      `DPGPIO_ADDR_PORT1_SEL: sfr_rdata = {5'h00, p1_sel_q};
      default: sfr_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_reset_seen;
    !rstn;
  endsequence
  a_reset_all_in: assert property (@(posedge ref_clk) s_reset_seen |=> (p0_pin_oe == 8'h00 && p1_pin_oe == 2'h0)) else $error("pin driven after reset");
  a_bit0_gpio: assert property (@(posedge ref_clk) disable iff (!rstn) ##1 (p0_pin_oe[0] == ~$past(port0_direction_q[0]))) else $error("bit0 direction wrong");
  a_txd_drives: assert property (@(posedge ref_clk) disable iff (!rstn) p0_sel_q[2] |=> p0_pin_oe[2]) else $error("txd not driven");
  a_pwm_drives: assert property (@(posedge ref_clk) disable iff (!rstn) p0_sel_q[7] |=> (p0_pin_oe[7] && p0_pin_out[7] == $past(pwm_out))) else $error("pwm not driven");
  a_irq_in: assert property (@(posedge ref_clk) disable iff (!rstn) (p0_sel_q[3] && p0_sel_q[4]) |=> !p0_pin_oe[3] && !p0_pin_oe[4]) else $error("irq pin driven");
  a_rxd_dir: assert property (@(posedge ref_clk) disable iff (!rstn) p0_sel_q[1] |=> (p0_pin_oe[1] == ~$past(port0_direction_q[1]))) else $error("rxd direction wrong");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rstn) !p0_sel_q[3] |=> ext_irq_a_n) else $error("irq a leaked");
  // Sampled reset in the antecedent keeps the release edge quiet
  a_spi_route: assert property (@(posedge ref_clk) disable iff (!rstn) (rstn && spi_on) |=> (p1_pin_oe == 2'h3 && p1_pin_out[0] == $past(spi_sck))) else $error("spi route wrong");
  a_gpio_dir: assert property (@(posedge ref_clk) disable iff (!rstn) (!p0_sel_q[5] && !port0_direction_q[5]) |=> p0_pin_oe[5]) else $error("gpio not driven");
endmodule : dpgpio_pin_mux
`default_nettype wire

//--- dv/dpgpio_board.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Board side of port0 and port1
// ****
module dpgpio_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pin_in
);
  // Released lines show the board pattern, never a stale echo
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule : dpgpio_board
`default_nettype wire

//--- dv/test_dpgpio_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpgpio_params.svh"
module test_dpgpio_pin_mux;
  import dpgpio_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, txd = 1'b1, pwm = 1'b0, din = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, drv = 8'h5a, rdata, pin_in, pin_out, pin_oe;
  logic [1:0] route = 2'h0, p1_out, p1_oe;
  logic [1:0] p1_drv = 2'h1;
  logic [7:0] p1_in8;
  logic rxd, irq_a, irq_b, t0, t1, t2, sdi;
  int miscompares = 0, tests_run = 0;
  // ****
  // Clock, board and device
  // ****
  always #10 ref_clk = ~ref_clk;
  dpgpio_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(drv), .pin_in(pin_in));
  dpgpio_board i_board1 (.pin_out({6'h00, p1_out}), .pin_oe({6'h00, p1_oe}),
    .ext_drv({6'h00, p1_drv}), .pin_in(p1_in8));
  dpgpio_pin_mux i_dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata), .spi_route(route),
    .p0_pin_in(pin_in), .p0_pin_out(pin_out), .p0_pin_oe(pin_oe), .p1_pin_in(p1_in8[1:0]),
    .p1_pin_out(p1_out), .p1_pin_oe(p1_oe), .input_only_pin(din), .uart_txd(txd),
    .uart_rxd(rxd), .uart_rxd_out(~pwm), .pwm_out(pwm), .ext_irq_a_n(irq_a),
    .ext_irq_b_n(irq_b), .timer0_count_in(t0), .timer1_count_in(t1),
    .timer2_count_in(t2), .spi_sck(txd), .spi_sdo(pwm), .spi_sdi(sdi));
  // ****
  // Access tasks
  // ****
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Waits out the one edge of pin latency plus margin
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    @(negedge ref_clk);
    chk("sfr_rdata", rdata, e);
  endtask : rd
  task automatic give_verdict;
    $display("Mismatches %0d of %0d checks", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("p0_pin_oe", pin_oe, 8'h00);
    chk("p1_pin_oe", {6'h00, p1_oe}, 8'h00);
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`DPGPIO_ADDR_PORT0_DIR, 8'hff);
    chk("p0_pin_oe", pin_oe, 8'h00);
    rd(`DPGPIO_ADDR_PORT0_SEL, 8'h00);
    rd(`DPGPIO_ADDR_PORT1_DIR, 8'h07);
    rd(`DPGPIO_ADDR_PORT1_SEL, 8'h00);
    rd(`DPGPIO_ADDR_PORT0_DATA, drv);
    rd(8'h81, 8'h00);
    wr(`DPGPIO_ADDR_PORT0_DIR, 8'h00);
    wr(`DPGPIO_ADDR_PORT0_DATA, 8'ha5);
    chk("p0_pin_oe", pin_oe, 8'hff);
    chk("p0_pin_out", pin_out, 8'ha5);
    rd(`DPGPIO_ADDR_PORT0_DATA, 8'ha5);
    wr(`DPGPIO_ADDR_PORT0_DIR, 8'hff);
    wr(`DPGPIO_ADDR_PORT0_SEL, 8'hff);
    chk("p0_pin_oe", pin_oe, 8'h84);
    chk("p0_pin_out", pin_out & 8'h84, 8'h04);
    @(posedge ref_clk);
    drv <= 8'ha5;
    txd <= 1'b0;
    pwm <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("rxd_irq_timer", {3'h0, rxd, irq_a, irq_b, t0, t1}, 8'h02);
    chk("p0_pin_out", pin_out & 8'h84, 8'h80);
    @(posedge ref_clk);
    txd <= 1'b1;
    pwm <= 1'b0;
    wr(`DPGPIO_ADDR_PORT0_DIR, 8'h00);
    chk("p0_pin_oe", pin_oe, 8'h87);
    chk("p0_pin_out", pin_out & 8'h87, 8'h07);
    wr(`DPGPIO_ADDR_PORT0_SEL, 8'h00);
    chk("rxd_irq_timer", {3'h0, rxd, irq_a, irq_b, t0, t1}, 8'h1c);
    chk("p0_pin_oe", pin_oe, 8'hff);
    wr(`DPGPIO_ADDR_PORT0_DATA, 8'ha4);
    wr(`DPGPIO_ADDR_PORT1_DATA, 8'h02);
    for (int r = 0; r < 4; r++) begin
      @(posedge ref_clk);
      route <= r[1:0];
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("p1_pin_oe", {6'h00, p1_oe}, (r == 1) ? 8'h03 : 8'h00);
      chk("spi_sdi", {7'h00, sdi}, (r == 1) ? {7'h00, din} : 8'h00);
      if (r == 1) chk("p1_pin_out", {6'h00, p1_out}, {6'h00, pwm, txd});
      if (r == 1) chk("p0_cs", {6'h00, pin_oe[0], pin_out[0]}, 8'h02);
      chk("timer2", {7'h00, t2}, 8'h00);
    end
    wr(`DPGPIO_ADDR_PORT1_SEL, 8'h01);
    chk("timer2", {7'h00, t2}, 8'h01);
    wr(`DPGPIO_ADDR_PORT1_DIR, 8'h00);
    chk("p1_pin_oe", {6'h00, p1_oe}, 8'h02);
    chk("p1_pin_out", {6'h00, p1_out}, 8'h02);
    rd(`DPGPIO_ADDR_PORT1_DATA, 8'h07);
    @(posedge ref_clk);
    route <= 2'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("timer2", {7'h00, t2}, 8'h00);
    // Reset in mid-run with SPI routed must still release every pin
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("p0_pin_oe", pin_oe, 8'h00);
    chk("p1_pin_oe", {6'h00, p1_oe}, 8'h00);
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`DPGPIO_ADDR_PORT0_DIR, 8'hff);
    rd(`DPGPIO_ADDR_PORT1_SEL, 8'h00);
    give_verdict();
  end
  // Guards against a hang anywhere above
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end
endmodule : test_dpgpio_pin_mux
`default_nettype wire
